// [rtl/dlct_pkg.sv]
package dlct_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;  // timer_control_status_reg
  localparam logic [3:0] ADDR_MODE = 4'h1;  // timer_mode_reg
  localparam logic [3:0] ADDR_T0L = 4'h2;
  localparam logic [3:0] ADDR_T1L = 4'h3;
  localparam logic [3:0] ADDR_T0H = 4'h4;
  localparam logic [3:0] ADDR_T1H = 4'h5;
  localparam logic [3:0] ADDR_PRESC = 4'h6; // clock_prescale_config_reg
  // timer_control_status_reg fields
  localparam int CTRL_RUN0 = 4;
  localparam int CTRL_FLAG0 = 5;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_FLAG1 = 7;
  // timer_mode_reg fields, second timer sits at MODE_T1_BASE
  localparam int MODE_M0 = 0;
  localparam int MODE_M1 = 1;
  localparam int MODE_SRC = 2;
  localparam int MODE_GATE = 3;
  localparam int MODE_T1_BASE = 4;
  // clock_prescale_config_reg: tick_divider_select_bits
  localparam int PRESC_SEL0 = 3;
  localparam int PRESC_SEL1 = 4;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam int PRESCALE_DIV = 12;
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : dlct_pkg

// [rtl/dlct_timers.sv]
// Behaviour
// - Timer mode advances once per tick: clock divided by one or twelve.
// - Counter mode advances on each falling edge at the count pin.
// - External events up to a quarter of the clock rate are counted.
// - Each timer has 16-bit count as low and high byte registers.
// - Two-bit mode field picks 13-bit, 16-bit, auto-reload or split mode.
// - 13-bit mode uses high byte and low five bits of low byte.
// - 13-bit wrap from all ones sets the overflow flag.
// - Source-select zero uses prescaled clock, one uses pin falling edges.
// - Counts only when run set and gate off or irq pin high.
// - Setting run does not alter the count.
// - Second timer behaves like the first with its own bits.
// - 16-bit mode uses all sixteen bits.
// - Auto-reload: low byte wraps, sets flag, reloads from unchanged high byte.
// - Split mode low byte uses first timer's run, gate, source and flag.
// - Split mode high byte counts ticks under second run bit, sets second flag.
// - Split mode selected on second timer stops it and holds its count.
// - With first timer split, second counts ticks only, no flag, still pulses.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dlct_timers (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Pins
  input wire logic firstCountInputPin,
  input wire logic secondCountInputPin,
  input wire logic firstExtIrqPin,
  input wire logic secondExtIrqPin,
  // Events
  output logic firstOverflowFlag,
  output logic secondOverflowFlag,
  output logic baudOverflowPulse
);
  import dlct_pkg::*;

  typedef struct packed {
    logic [3:0] presc;
    logic [1:0] cntSync1;
    logic [1:0] cntSync2;
    logic [1:0] cntPrev;
    logic [1:0] irqSync1;
    logic [1:0] irqSync2;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] prescCfg;
    logic [1:0][7:0] lowByte;
    logic [1:0][7:0] highByte;
    logic [7:0] rdata;
    logic baud;
  } dlct_state_type;

  dlct_state_type st_r;
  dlct_state_type st_nxt;

  logic tick12;
  logic [1:0] tick;
  logic [1:0] pinFall;
  logic [1:0] enable;
  logic [1:0] step;
  logic [1:0] wrap;
  logic [1:0][1:0] tmMode;
  logic [1:0] srcSel;
  logic [1:0] gateOn;
  logic [1:0] runBit;
  logic [1:0] flagSet;
  logic highSplitWrap;
  logic split0;
  logic [7:0] rd;

  always_comb begin
    tick12 = (st_r.presc == 4'(PRESCALE_DIV - 1));
    split0 = (st_r.mode[MODE_M1:MODE_M0] == MODE_SPLIT);
    runBit[0] = st_r.ctrl[CTRL_RUN0];
    runBit[1] = st_r.ctrl[CTRL_RUN1];
    tick[0] = st_r.prescCfg[PRESC_SEL0] ? 1'b1 : tick12;
    tick[1] = st_r.prescCfg[PRESC_SEL1] ? 1'b1 : tick12;
    for (int i = 0; i < 2; i++) begin
      tmMode[i] = st_r.mode[i*MODE_T1_BASE+MODE_M0 +: 2];
      srcSel[i] = st_r.mode[i*MODE_T1_BASE+MODE_SRC];
      gateOn[i] = st_r.mode[i*MODE_T1_BASE+MODE_GATE];
      // Falling edge seen on synchronised samples only
      pinFall[i] = st_r.cntPrev[i] & ~st_r.cntSync2[i];
    end
    // Second timer: external source ignored while first is split; its gating still applies
    if (split0) begin
      srcSel[1] = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      enable[i] = runBit[i] & (~gateOn[i] | st_r.irqSync2[i]);
      step[i] = enable[i] & (srcSel[i] ? pinFall[i] : tick[i]);
    end
    if (tmMode[1] == MODE_SPLIT) begin
      step[1] = 1'b0;
    end
    highSplitWrap = split0 & runBit[1] & tick[0] & (st_r.highByte[0] == 8'hFF);

    st_nxt = st_r;
    st_nxt.presc = tick12 ? 4'h0 : st_r.presc + 4'h1;
    st_nxt.cntSync1 = {secondCountInputPin, firstCountInputPin};
    st_nxt.cntSync2 = st_r.cntSync1;
    st_nxt.cntPrev = st_r.cntSync2;
    st_nxt.irqSync1 = {secondExtIrqPin, firstExtIrqPin};
    st_nxt.irqSync2 = st_r.irqSync1;

    // Register writes first, counting afterwards so run does not touch count
    if (regWr) begin
      case (regAddr)
        ADDR_CTRL: st_nxt.ctrl = regWdata;
        ADDR_MODE: st_nxt.mode = regWdata;
        ADDR_T0L: st_nxt.lowByte[0] = regWdata;
        ADDR_T1L: st_nxt.lowByte[1] = regWdata;
        ADDR_T0H: st_nxt.highByte[0] = regWdata;
        ADDR_T1H: st_nxt.highByte[1] = regWdata;
        ADDR_PRESC: st_nxt.prescCfg = regWdata;
        default: ;
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      wrap[i] = 1'b0;
      if (step[i]) begin
        case (tmMode[i])
          MODE_13BIT: begin
            wrap[i] = (st_r.highByte[i] == 8'hFF) & (st_r.lowByte[i][4:0] == 5'h1F);
            st_nxt.lowByte[i] = {st_r.lowByte[i][7:5], st_r.lowByte[i][4:0] + 5'h01};
            if (st_r.lowByte[i][4:0] == 5'h1F) begin
              st_nxt.highByte[i] = st_r.highByte[i] + 8'h01;
            end
          end
          MODE_16BIT: begin
            wrap[i] = ({st_r.highByte[i], st_r.lowByte[i]} == 16'hFFFF);
            {st_nxt.highByte[i], st_nxt.lowByte[i]} = {st_r.highByte[i], st_r.lowByte[i]} + 16'h0001;
          end
          MODE_RELOAD: begin
            wrap[i] = (st_r.lowByte[i] == 8'hFF);
            st_nxt.lowByte[i] = wrap[i] ? st_r.highByte[i] : st_r.lowByte[i] + 8'h01;
          end
          MODE_SPLIT: begin
            // Only the first timer reaches here; low byte is a plain 8-bit counter
            wrap[i] = (st_r.lowByte[i] == 8'hFF);
            st_nxt.lowByte[i] = st_r.lowByte[i] + 8'h01;
          end
          default: ;
        endcase
      end
    end
    if (split0 & runBit[1] & tick[0]) begin
      st_nxt.highByte[0] = st_r.highByte[0] + 8'h01;
    end

    // Hardware set wins over a software clear in the same cycle
    flagSet[0] = wrap[0];
    flagSet[1] = split0 ? highSplitWrap : wrap[1];
    if (flagSet[0]) begin
      st_nxt.ctrl[CTRL_FLAG0] = 1'b1;
    end
    if (flagSet[1]) begin
      st_nxt.ctrl[CTRL_FLAG1] = 1'b1;
    end
    st_nxt.baud = wrap[1];

    case (regAddr)
      ADDR_CTRL: rd = st_r.ctrl;
      ADDR_MODE: rd = st_r.mode;
      ADDR_T0L: rd = st_r.lowByte[0];
      ADDR_T1L: rd = st_r.lowByte[1];
      ADDR_T0H: rd = st_r.highByte[0];
      ADDR_T1H: rd = st_r.highByte[1];
      ADDR_PRESC: rd = st_r.prescCfg;
      default: rd = RESET_BYTE;
    endcase
    st_nxt.rdata = regRd ? rd : RESET_BYTE;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    regRdata = st_r.rdata;
    firstOverflowFlag = st_r.ctrl[CTRL_FLAG0];
    secondOverflowFlag = st_r.ctrl[CTRL_FLAG1];
    baudOverflowPulse = st_r.baud;
  end
endmodule : dlct_timers
`default_nettype wire

// [tb/dlct_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dlct_pin_model (
  // Clock
  input wire logic clk_sys,
  // Pin
  output var logic pin
);
  initial pin = 1'b1;
  // Two clocks per level keeps the rate at a quarter of the clock
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk_sys) pin <= 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys) pin <= 1'b1;
      @(posedge clk_sys);
    end
  endtask : burst
endmodule : dlct_pin_model
`default_nettype wire

// [tb/dlct_timers_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module dlct_timers_sva
  import dlct_pkg::*;
(
  // Bus
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Events
  input wire logic firstOverflowFlag,
  input wire logic secondOverflowFlag,
  input wire logic baudOverflowPulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic ctrlWr = regWr && regAddr == ADDR_CTRL;
  rd_idle_a: assert property (!regRd |=> regRdata == 8'h00) else $error("idle data");
  rd_unmapped_a: assert property (regRd && regAddr > ADDR_PRESC |=> regRdata == 8'h00) else $error("unmapped");
  flag0_read_a: assert property (regRd && regAddr == ADDR_CTRL |=> regRdata[CTRL_FLAG0] == $past(firstOverflowFlag))
    else $error("flag0 read");
  flag1_read_a: assert property (regRd && regAddr == ADDR_CTRL |=> regRdata[CTRL_FLAG1] == $past(secondOverflowFlag))
    else $error("flag1 read");
  flag0_hold_a: assert property (firstOverflowFlag && !ctrlWr |=> firstOverflowFlag) else $error("flag0 lost");
  flag1_hold_a: assert property (secondOverflowFlag && !ctrlWr |=> secondOverflowFlag) else $error("flag1 lost");
  flag0_set_a: assert property (ctrlWr && regWdata[CTRL_FLAG0] |=> firstOverflowFlag) else $error("flag0 set");
  mode_back_a: assert property (regWr && regAddr == ADDR_MODE ##2 regRd && regAddr == ADDR_MODE
    |=> regRdata == $past(regWdata, 3)) else $error("mode read");
  cover property ($rose(firstOverflowFlag));
  cover property ($rose(secondOverflowFlag));
  cover property (baudOverflowPulse);
endmodule : dlct_timers_sva
bind dlct_timers dlct_timers_sva chk (.*);
`default_nettype wire

// [tb/test_dual_legacy_counter_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_legacy_counter_timer;
  import dlct_pkg::*;
  logic clk_sys, arst_n, regWr, regRd, firstExtIrqPin, secondExtIrqPin;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, d, r;
  wire logic firstCountInputPin, secondCountInputPin, firstOverflowFlag, secondOverflowFlag, baudOverflowPulse;
  int err_total = 0, compares = 0, k0, k1, baudCnt = 0, b0;
  dlct_timers DUT (.*);
  dlct_pin_model modelA (.clk_sys(clk_sys), .pin(firstCountInputPin));
  dlct_pin_model modelB (.clk_sys(clk_sys), .pin(secondCountInputPin));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (baudOverflowPulse === 1'b1) begin
      baudCnt++;
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkRange(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chkRange
  task automatic rv(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rv
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdata & m, e);
  endtask : rc
  function automatic logic [7:0] reloadExp(input logic [7:0] rl, input int n);
    return rl + 8'(n - 1);
  endfunction : reloadExp
  task automatic tally_and_finish;
    $display("Mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    {regWr, regRd, firstExtIrqPin, secondExtIrqPin, arst_n} = '0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    k0 = $urandom(11425);
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int a = 2; a < 6; a++) begin
      d = 8'($urandom);
      wr(4'(a), d);
      rc(4'(a), 8'hFF, d);
    end
    rc(4'hF, 8'hFF, 8'h00);
    // First timer 13-bit on its pin, second auto-reload on its pin
    k0 = 1 + $urandom % 32;
    k1 = 1 + $urandom % 15;
    d = 8'($urandom % 241);
    wr(ADDR_MODE, 8'h64);
    rc(ADDR_MODE, 8'hFF, 8'h64);
    wr(ADDR_T0L, 8'h1F);
    wr(ADDR_T0H, 8'hFF);
    wr(ADDR_T1L, 8'hFF);
    wr(ADDR_T1H, d);
    wr(ADDR_CTRL, 8'h50);
    fork
      modelA.burst(k0);
      modelB.burst(k1);
    join
    repeat (6) @(posedge clk_sys);
    #1 chk({6'h00, secondOverflowFlag, firstOverflowFlag}, 8'h03);
    rc(ADDR_CTRL, 8'hF0, 8'hF0);
    rc(ADDR_T0L, 8'h1F, 8'(k0 - 1));
    rc(ADDR_T0H, 8'hFF, 8'h00);
    rc(ADDR_T1L, 8'hFF, reloadExp(d, k1));
    rc(ADDR_T1H, 8'hFF, d);
    // Gated 16-bit count: edges with the gate pin low are ignored
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h0D);
    wr(ADDR_T0L, 8'h05);
    wr(ADDR_T0H, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    modelA.burst(3);
    repeat (6) @(posedge clk_sys);
    firstExtIrqPin <= 1'b1;
    modelA.burst(2);
    repeat (6) @(posedge clk_sys);
    rc(ADDR_T0L, 8'hFF, 8'h07);
    // First timer split on divided ticks, second reload on every clock with its gate open
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PRESC, 8'h10);
    wr(ADDR_MODE, 8'hE3);
    secondExtIrqPin <= 1'b1;
    wr(ADDR_T0L, 8'hFC);
    wr(ADDR_T0H, 8'h00);
    wr(ADDR_T1L, 8'hFD);
    wr(ADDR_T1H, 8'hF0);
    b0 = baudCnt;
    wr(ADDR_CTRL, 8'h50);
    repeat (480) @(posedge clk_sys);
    #1 chk({6'h00, secondOverflowFlag, firstOverflowFlag}, 8'h01);
    chkRange(baudCnt - b0, 28, 32);
    wr(ADDR_CTRL, 8'h00);
    rv(ADDR_T0H, r);
    chkRange(int'(r), 39, 42);
    // Split selected on the second timer stops it and its overflow pulses
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_T1L, 8'hA5);
    wr(ADDR_CTRL, 8'h40);
    b0 = baudCnt;
    repeat (50) @(posedge clk_sys);
    rc(ADDR_T1L, 8'hFF, 8'hA5);
    chk(8'(baudCnt - b0), 8'h00);
    tally_and_finish();
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
endmodule : test_dual_legacy_counter_timer
`default_nettype wire
